// file: design/bus_line_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module bus_line_monitor
  import sensor_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_sync_n,
  // bus lines, taken as synchronous
  input  wire logic scl_in,
  input  wire logic sda_in,
  // decoded events
  output var  line_evt_t evt
);

  mon_state_t q;
  mon_state_t d;

  // edge and start/stop detection against the previous line levels
  always_comb begin
    d           = q;
    d.scl_q     = scl_in;
    d.sda_q     = sda_in;
    d.evt.start = scl_in & q.scl_q & q.sda_q & ~sda_in;
    d.evt.stop  = scl_in & q.scl_q & ~q.sda_q & sda_in;
    d.evt.rise  = scl_in & ~q.scl_q;
    d.evt.fall  = ~scl_in & q.scl_q;
    d.evt.sda   = sda_in;
  end

  // idle bus is high on both lines
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      q <= '{scl_q: 1'b1, sda_q: 1'b1, evt: '{sda: 1'b1, default: 1'b0}};
    end else begin
      q <= d;
    end
  end

  assign evt = q.evt;

endmodule // bus_line_monitor
`default_nettype wire

// file: design/sensor_pkg.sv
// Behaviour
// - conversion result is 24 bits over read-only bytes 0x00 (high), 0x01, 0x02 (low).
// - low power mode keeps 22 significant bits, standard and high accuracy keep 24.
// - unused low result bits 1 and 0 read as zero in low power mode.
// - result bytes are read-only, reset to zero, writes ignored.
// - a multi-byte read from 0x00 walks through the result bytes by auto-increment.
// - sense request bit 5 reads the sleep state, one means sleeping.
// - writing one to sense request bit 4 wakes the device; it starts a conversion only while setup holds code 1_0.
// - sense request bits 3 to 1 pick low power, standard or high accuracy mode.
// - sense request bit 0 picks thermal element (one) or pressure element (zero).
// - converter setup bits 1 to 0 take code 1_0 only; upper bits written zero. The code stores any two-bit value written to bits 1 to 0.
// - coefficient registers 0x22 to 0x34 are 16-bit read-only factory values.
// - extension register carries bits 23:16 of the two offset coefficients.
// - result bytes go high, low, extra-low, each most significant bit first.
// - device answers at 7-bit bus address 0x70 (E0h write, E1h read).
package sensor_pkg;

  // register offsets
  localparam logic [7:0] OFF_RESULT_HIGH  = 8'h00;
  localparam logic [7:0] OFF_RESULT_MID   = 8'h01;
  localparam logic [7:0] OFF_RESULT_LOW   = 8'h02;
  localparam logic [7:0] OFF_SENSE_REQ    = 8'h03;
  localparam logic [7:0] OFF_CALIB_CTL    = 8'h08;
  localparam logic [7:0] OFF_CONV_SETUP   = 8'h0a;
  localparam logic [7:0] OFF_PRESS_GAIN   = 8'h22;
  localparam logic [7:0] OFF_PRESS_OFS    = 8'h24;
  localparam logic [7:0] OFF_TEMP_GAIN    = 8'h26;
  localparam logic [7:0] OFF_TEMP_OFS     = 8'h28;
  localparam logic [7:0] OFF_TEMP_GAIN_B  = 8'h2a;
  localparam logic [7:0] OFF_TEMP_OFS_B   = 8'h2c;
  localparam logic [7:0] OFF_THERM_GAIN   = 8'h2e;
  localparam logic [7:0] OFF_THERM_OFS    = 8'h32;
  localparam logic [7:0] OFF_COEF_EXT     = 8'h34;

  // bus address and field layout
  localparam logic [6:0] BUS_ADDR_DEFAULT = 7'h70;
  localparam int         SREQ_SLEEP_BIT   = 5;
  localparam int         SREQ_WAKE_BIT    = 4;
  localparam int         SREQ_MODE_HI     = 3;
  localparam int         SREQ_MODE_LO     = 1;
  localparam int         SREQ_SEL_BIT     = 0;
  localparam int         CALCTL_DIS_BIT   = 6;
  localparam logic [7:0] CALCTL_FIXED     = 8'h25;
  localparam logic       CALCTL_DIS_RESET = 1'b1;
  localparam logic [1:0] SETUP_RESET      = 2'h0;
  localparam logic [1:0] SETUP_START      = 2'h2;
  localparam int         LOW_PAD_BITS     = 2;

  // measurement mode codes
  localparam logic [2:0] MODE_LOW_POWER   = 3'h0;
  localparam logic [2:0] MODE_STANDARD    = 3'h2;
  localparam logic [2:0] MODE_HIGH_ACC    = 3'h3;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK
  } bus_state_t;

  // factory calibration words
  typedef struct packed {
    logic [15:0] press_gain_coef;
    logic [15:0] press_offset_coef;
    logic [15:0] temp_gain_coef;
    logic [15:0] temp_offset_coef;
    logic [15:0] temp_gain_coef_b;
    logic [15:0] temp_offset_coef_b;
    logic [15:0] thermal_gain_coef;
    logic [15:0] thermal_offset_coef;
    logic [15:0] coef_extension;
  } calib_t;

  // decoded bus line events
  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic sda;
  } line_evt_t;

  typedef struct packed {
    logic      scl_q;
    logic      sda_q;
    line_evt_t evt;
  } mon_state_t;

  typedef struct packed {
    bus_state_t  st;
    logic [2:0]  cnt;
    logic        got;
    logic [7:0]  sh;
    logic [7:0]  tx;
    logic [7:0]  ptr;
    logic        rw;
    logic        sda_oe;
    logic [23:0] result;
    logic [2:0]  mode;
    logic        sel;
    logic        sleep;
    logic        calib_dis;
    logic [1:0]  setup;
    logic        conv_start;
  } regs_state_t;

endpackage

// file: design/sensor_regs.sv
`timescale 1ns/1ps
`default_nettype none
module sensor_regs
  import sensor_pkg::*;
#(
  parameter logic [6:0] BUS_ADDR = BUS_ADDR_DEFAULT
)(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // two-wire bus, open drain data
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // converter side
  input  wire logic        conv_valid,
  input  wire logic [23:0] conv_data,
  input  wire calib_t      calib,
  output logic             conv_start,
  output logic [2:0]       meas_mode,
  output logic             input_select,
  output logic [1:0]       setup_code,
  output logic             calib_read_en,
  output logic             sleep_state
);

  // elaboration check: reserved 7-bit addresses cannot be served
  if (BUS_ADDR < 7'h08 || BUS_ADDR > 7'h77) begin : g_addr_check
    $error("bus address out of usable range");
  end

  logic [1:0]  rst_sync_q;
  logic        rst_sync_n;
  line_evt_t   evt;
  regs_state_t q;
  regs_state_t d;
  logic        load_evt;
  logic        wr_evt;

  // reset release through two flops
  // asserts at once, releases on an edge so no flop leaves reset on a race
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_sync_q[1];

  bus_line_monitor u_mon (
    .clock      (clock),
    .rst_sync_n (rst_sync_n),
    .scl_in     (scl_in),
    .sda_in     (sda_in),
    .evt        (evt)
  );

  // result formatting by mode
  // low power delivers only 22 valid bits; the two below are forced to zero
  function automatic logic [23:0] fmt_result(input logic [23:0] raw, input logic [2:0] mode);
    logic [23:0] r;
    r = raw;
    if (mode == MODE_LOW_POWER) begin
      r[LOW_PAD_BITS-1:0] = '0;
    end
    return r;
  endfunction

  // coefficient byte: even offset is the high byte, odd the low byte
  // gaps between coefficient words read as zero
  function automatic logic [7:0] coef_byte(input calib_t c, input logic [7:0] a);
    logic [15:0] w;
    w = 16'h0000;
    unique case ({a[7:1], 1'b0})
      OFF_PRESS_GAIN:  w = c.press_gain_coef;
      OFF_PRESS_OFS:   w = c.press_offset_coef;
      OFF_TEMP_GAIN:   w = c.temp_gain_coef;
      OFF_TEMP_OFS:    w = c.temp_offset_coef;
      OFF_TEMP_GAIN_B: w = c.temp_gain_coef_b;
      OFF_TEMP_OFS_B:  w = c.temp_offset_coef_b;
      OFF_THERM_GAIN:  w = c.thermal_gain_coef;
      OFF_THERM_OFS:   w = c.thermal_offset_coef;
      OFF_COEF_EXT:    w = c.coef_extension; // upper offsets' bits 23:16
      default:         w = 16'h0000;
    endcase
    return a[0] ? w[7:0] : w[15:8];
  endfunction

  // read decode of the whole map
  function automatic logic [7:0] read_byte(input regs_state_t s, input calib_t c);
    logic [7:0] b;
    b = 8'h00;
    unique case (s.ptr)
      OFF_RESULT_HIGH: b = s.result[23:16];
      OFF_RESULT_MID:  b = s.result[15:8];
      OFF_RESULT_LOW:  b = s.result[7:0];
      OFF_SENSE_REQ: begin
        b[SREQ_SLEEP_BIT]              = s.sleep;
        b[SREQ_MODE_HI:SREQ_MODE_LO]   = s.mode;
        b[SREQ_SEL_BIT]                = s.sel; // wake bit reads zero
      end
      OFF_CALIB_CTL: begin
        b                 = CALCTL_FIXED;
        b[CALCTL_DIS_BIT] = s.calib_dis;
      end
      OFF_CONV_SETUP:  b = {6'h00, s.setup};
      default: begin
        if (!s.calib_dis) begin // reads gated until enabled
          b = coef_byte(c, s.ptr);
        end
      end
    endcase
    return b;
  endfunction

  // next-state logic: bus protocol, register writes, conversion capture
  always_comb begin
    d            = q;
    d.conv_start = 1'b0;
    // stop and start cut any transfer, so a confused host can always recover
    if (evt.stop) begin
      d.st     = ST_IDLE;
      d.sda_oe = 1'b0;
    end else if (evt.start) begin
      d.st     = ST_ADDR;
      d.cnt    = 3'h0;
      d.got    = 1'b0;
      d.sda_oe = 1'b0;
    end else begin
      unique case (q.st)
        ST_IDLE: begin
          d.got = 1'b0;
        end
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (evt.rise) begin
            d.sh  = {q.sh[6:0], evt.sda};
            d.cnt = q.cnt + 3'h1;
            d.got = (q.cnt == 3'h7);
          end
          if (evt.fall && q.got) begin
            d.got = 1'b0;
            if (q.st == ST_ADDR) begin
              if (q.sh[7:1] == BUS_ADDR) begin
                d.rw     = q.sh[0];
                d.sda_oe = 1'b1;
                d.st     = ST_ADDR_ACK;
              end else begin
                d.st = ST_IDLE;
              end
            end else if (q.st == ST_PTR) begin
              d.ptr    = q.sh;
              d.sda_oe = 1'b1;
              d.st     = ST_PTR_ACK;
            end else begin
              // result and coefficient offsets fall to default
              unique case (q.ptr)
                OFF_SENSE_REQ: begin
                  d.mode = q.sh[SREQ_MODE_HI:SREQ_MODE_LO];
                  d.sel  = q.sh[SREQ_SEL_BIT];
                  if (q.sh[SREQ_WAKE_BIT]) begin
                    d.sleep      = 1'b0;
                    d.conv_start = (q.setup == SETUP_START);
                  end
                end
                OFF_CALIB_CTL:  d.calib_dis = q.sh[CALCTL_DIS_BIT];
                OFF_CONV_SETUP: d.setup     = q.sh[1:0];
                default:        d.setup     = q.setup;
              endcase
              d.ptr    = q.ptr + 8'h01;
              d.sda_oe = 1'b1;
              d.st     = ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK, ST_RACK: begin
          if (q.st == ST_RACK && evt.rise) begin
            d.got = ~evt.sda;
            if (evt.sda) begin
              d.st = ST_IDLE; // host ends the read with a nack
            end
          end
          if (evt.fall && ((q.st == ST_ADDR_ACK) ? q.rw : q.got)) begin
            // load next byte, auto-increment pointer
            d.tx     = read_byte(q, calib);
            d.ptr    = q.ptr + 8'h01;
            d.sda_oe = ~d.tx[7]; // msb first
            d.cnt    = 3'h0;
            d.got    = 1'b0;
            d.st     = ST_RDATA;
          end else if (evt.fall && q.st == ST_ADDR_ACK) begin
            d.sda_oe = 1'b0;
            d.cnt    = 3'h0;
            d.st     = ST_PTR;
          end
        end
        ST_PTR_ACK, ST_WDATA_ACK: begin
          if (evt.fall) begin
            d.sda_oe = 1'b0;
            d.cnt    = 3'h0;
            d.st     = ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (evt.fall) begin
            d.cnt = q.cnt + 3'h1;
            if (q.cnt == 3'h7) begin
              d.sda_oe = 1'b0;
              d.st     = ST_RACK;
            end else begin
              d.tx     = {q.tx[6:0], 1'b0};
              d.sda_oe = ~q.tx[6];
            end
          end
        end
      endcase
    end
    // conversion done: capture and go back to sleep; set wins over wake
    // placed last so a wake write in the same cycle cannot hide the finished result
    if (conv_valid) begin
      d.result = fmt_result(conv_data, q.mode);
      d.sleep  = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      q           <= '0;
      q.st        <= ST_IDLE;
      q.calib_dis <= CALCTL_DIS_RESET;
      q.setup     <= SETUP_RESET;
    end else begin
      q <= d;
    end
  end

  // outputs
  // the data pin is open drain: only the enable moves, the driven level stays low
  assign sda_out       = 1'b0;
  assign sda_oe        = q.sda_oe;
  assign conv_start    = q.conv_start;
  assign meas_mode     = q.mode;
  assign input_select  = q.sel;
  assign setup_code    = q.setup;
  assign calib_read_en = ~q.calib_dis;
  assign sleep_state   = q.sleep;

  // helper for checks: a read byte is loaded this cycle
  assign load_evt = evt.fall && !evt.start && !evt.stop &&
                    ((q.st == ST_ADDR_ACK && q.rw) || (q.st == ST_RACK && q.got));

  // helper for checks: a written data byte is taken this cycle
  assign wr_evt = evt.fall && q.got && !evt.start && !evt.stop && q.st == ST_WDATA;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_sync_n);

  a_low_pad_zero: assert property (conv_valid && q.mode == MODE_LOW_POWER |=>
    q.result[1:0] == 2'h0) else $error("low power result not padded");

  a_result_capture: assert property (conv_valid |=>
    q.result == fmt_result($past(conv_data), $past(q.mode))) else $error("result not captured");

  a_result_ro: assert property (!conv_valid ##1 !conv_valid |->
    q.result == $past(q.result)) else $error("result changed without conversion");

  a_sleep_read: assert property (load_evt && q.ptr == OFF_SENSE_REQ |=>
    q.tx[SREQ_SLEEP_BIT] == $past(q.sleep) && !q.tx[SREQ_WAKE_BIT]) else $error("sleep bit bad");

  a_wake_start: assert property (q.st == ST_WDATA && evt.fall && q.got && !evt.start &&
    !evt.stop && q.ptr == OFF_SENSE_REQ && q.sh[SREQ_WAKE_BIT] && q.setup == SETUP_START |=>
    q.conv_start ##1 !q.conv_start) else $error("wake did not start conversion");

  a_calib_gate: assert property (load_evt && q.calib_dis && q.ptr >= OFF_PRESS_GAIN |=>
    q.tx == 8'h00) else $error("coefficient readable while disabled");

  a_ptr_advance: assert property (load_evt |=>
    q.ptr == $past(q.ptr) + 8'h01 && q.st == ST_RDATA) else $error("pointer did not advance");

  a_addr_reject: assert property (q.st == ST_ADDR && evt.fall && q.got && !evt.start &&
    !evt.stop && q.sh[7:1] != BUS_ADDR |=> q.st == ST_IDLE && !q.sda_oe)
    else $error("foreign address answered");

  a_setup_reserved: assert property (load_evt && q.ptr == OFF_CONV_SETUP |=>
    q.tx[7:2] == 6'h00) else $error("reserved setup bits not zero");

  // write path checks
  a_mode_write: assert property (wr_evt && q.ptr == OFF_SENSE_REQ |=>
    q.mode == $past(q.sh[SREQ_MODE_HI:SREQ_MODE_LO]))
    else $error("mode field not stored");

  a_select_write: assert property (wr_evt && q.ptr == OFF_SENSE_REQ |=>
    q.sel == $past(q.sh[SREQ_SEL_BIT]))
    else $error("input select not stored");

  a_wake_clear: assert property (wr_evt && q.ptr == OFF_SENSE_REQ && !conv_valid &&
    q.sh[SREQ_WAKE_BIT] |=> !q.sleep)
    else $error("wake did not clear sleep");

  a_calib_write: assert property (wr_evt && q.ptr == OFF_CALIB_CTL |=>
    q.calib_dis == $past(q.sh[CALCTL_DIS_BIT]))
    else $error("calibration read gate not stored");

  a_setup_write: assert property (wr_evt && q.ptr == OFF_CONV_SETUP |=>
    q.setup == $past(q.sh[1:0]))
    else $error("setup code not stored");

  a_write_advance: assert property (wr_evt |=>
    q.ptr == $past(q.ptr) + 8'h01 && q.st == ST_WDATA_ACK && q.sda_oe)
    else $error("write not acked or pointer stuck");

  // read path checks
  a_ack_drive: assert property (q.st == ST_ADDR && evt.fall && q.got && !evt.start &&
    !evt.stop && q.sh[7:1] == BUS_ADDR |=> q.st == ST_ADDR_ACK && q.sda_oe)
    else $error("own address not acked");

  a_result_read: assert property (load_evt && q.ptr == OFF_RESULT_HIGH |=>
    q.tx == $past(q.result[23:16]))
    else $error("result high byte wrong");

  a_coef_high: assert property (load_evt && !q.calib_dis && q.ptr == OFF_PRESS_GAIN |=>
    q.tx == $past(calib.press_gain_coef[15:8]))
    else $error("coefficient high byte wrong");

  a_ext_low: assert property (load_evt && !q.calib_dis && q.ptr == OFF_COEF_EXT + 8'h01 |=>
    q.tx == $past(calib.coef_extension[7:0]))
    else $error("extension low byte wrong");

  a_shift_msb: assert property (q.st == ST_RDATA && evt.fall && q.cnt != 3'h7 &&
    !evt.start && !evt.stop |=> q.sda_oe == !$past(q.tx[6]))
    else $error("read bit order wrong");

  a_rack_release: assert property (q.st == ST_RACK |-> !q.sda_oe)
    else $error("data line held during host answer");

  // converter side checks
  a_sleep_set: assert property (conv_valid |=> q.sleep)
    else $error("sleep flag not set by conversion");

endmodule // sensor_regs
`default_nettype wire

// file: dv/i2c_host.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_host #(
  parameter logic [6:0] DEV = 7'h70
)(
  // clock
  input  wire logic clock,
  // bus lines, open drain data
  input  wire logic sda,
  output var  logic scl,
  output var  logic oe
);
  // bus idles released
  initial begin
    scl = 1'b1;
    oe  = 1'b0;
  end

  // wait n edges, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // one bit: data set while scl low, sampled at the end of the high phase
  task automatic bit_io(input logic b, output logic r);
    oe = ~b;
    tick(4);
    scl = 1'b1;
    tick(4);
    r = sda;
    scl = 1'b0;
    tick(1);
  endtask

  // start or repeated start
  task automatic start();
    oe = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(4);
    oe = 1'b1;
    tick(4);
    scl = 1'b0;
    tick(1);
  endtask

  // stop, bus left released
  task automatic stop();
    oe = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(4);
    oe = 1'b0;
    tick(4);
  endtask

  // byte out, msb first, returns the device acknowledge
  task automatic send(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // byte in, host acks all but the last byte
  task automatic recv(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(last, r);
  endtask

  // pointer then one data byte
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start();
    send({DEV, 1'b0}, a0);
    send(ptr, a1);
    send(d, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask

  // pointer, repeated start, n bytes packed high byte first
  task automatic rd(input logic [7:0] ptr, input int n, output logic [23:0] d);
    logic       a;
    logic [7:0] b;
    start();
    send({DEV, 1'b0}, a);
    send(ptr, a);
    start();
    send({DEV, 1'b1}, a);
    d = 24'h0;
    for (int k = 0; k < n; k++) begin
      recv(k == n - 1, b);
      d = {d[15:0], b};
    end
    stop();
  endtask

  // address byte alone, reports acknowledge
  task automatic probe(input logic [6:0] a, output logic ack);
    start();
    send({a, 1'b0}, ack);
    stop();
  endtask
endmodule // i2c_host
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sensor_pkg::*;
  localparam int LIMIT = 40000;
  logic        clock, rstn, conv_valid, sda_out, sda_oe, host_oe, scl;
  logic        conv_start, input_select, calib_read_en, sleep_state, ok;
  logic [23:0] conv_data, d;
  logic [2:0]  meas_mode;
  logic [1:0]  setup_code;
  calib_t      calib;
  wire logic   sda;
  int          n_errors, n_checks, n_start, cycles;

  // pulled-up wire, low when either side pulls
  assign sda = !((sda_oe && !sda_out) || host_oe);

  sensor_regs i_dut (.clock(clock), .rstn(rstn), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .conv_valid(conv_valid),
    .conv_data(conv_data), .calib(calib), .conv_start(conv_start),
    .meas_mode(meas_mode), .input_select(input_select), .setup_code(setup_code),
    .calib_read_en(calib_read_en), .sleep_state(sleep_state));

  i2c_host i_host (.clock(clock), .sda(sda), .scl(scl), .oe(host_oe));

  // clock and timeout
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (conv_start === 1'b1) n_start++;
    if (cycles == LIMIT) begin
      n_errors++;
      $display("BAD %0t timeout", $time);
      close_out();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // compare tasks
  task automatic chk_val(input logic [23:0] g, input logic [23:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t value %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t flag %b expected %b", $time, g, e);
    end
  endtask

  // one converter result pulse
  task automatic convert(input logic [23:0] v);
    conv_valid = 1'b1;
    conv_data  = v;
    step(1);
    conv_valid = 1'b0;
    step(2);
  endtask

  task automatic t_reset();
    i_host.rd(OFF_RESULT_HIGH, 3, d);
    chk_val(d, 24'h0);
    i_host.rd(OFF_SENSE_REQ, 1, d);
    chk_val(d, 24'h0);
    i_host.rd(OFF_CALIB_CTL, 1, d);
    chk_val(d, 24'h65);
    i_host.rd(OFF_CONV_SETUP, 1, d);
    chk_val(d, 24'h0);
    chk_bit(calib_read_en, 1'b0);
    chk_bit(sleep_state, 1'b0);
    $display("t_reset done");
  endtask

  task automatic t_mode();
    logic [2:0] m[3];
    int         s;
    m = '{MODE_LOW_POWER, MODE_STANDARD, MODE_HIGH_ACC};
    i_host.wr(OFF_CONV_SETUP, 8'h02, ok);
    chk_bit(ok, 1'b1);
    chk_val(24'(setup_code), 24'h2);
    foreach (m[k]) begin
      s = n_start;
      i_host.wr(OFF_SENSE_REQ, {4'h1, m[k], 1'b0}, ok);
      chk_val(24'(meas_mode), 24'(m[k]));
      chk_val(24'(n_start - s), 24'h1);
      i_host.rd(OFF_SENSE_REQ, 1, d);
      chk_val(d, {20'h0, m[k], 1'b0});
    end
    i_host.wr(OFF_SENSE_REQ, 8'h17, ok);
    chk_bit(input_select, 1'b1);
    $display("t_mode done");
  endtask

  task automatic t_result();
    convert(24'habcdef);
    chk_bit(sleep_state, 1'b1);
    i_host.rd(OFF_SENSE_REQ, 1, d);
    chk_val(d, 24'h27);
    i_host.rd(OFF_RESULT_HIGH, 3, d);
    chk_val(d, 24'habcdef);
    i_host.rd(OFF_RESULT_LOW, 1, d);
    chk_val(d, 24'hef);
    i_host.wr(OFF_RESULT_HIGH, 8'h55, ok);
    i_host.rd(OFF_RESULT_HIGH, 1, d);
    chk_val(d, 24'hab);
    i_host.wr(OFF_SENSE_REQ, 8'h00, ok);
    chk_bit(sleep_state, 1'b1);
    chk_bit(input_select, 1'b0);
    i_host.wr(OFF_SENSE_REQ, 8'h10, ok);
    chk_bit(sleep_state, 1'b0);
    convert(24'habcdef);
    i_host.rd(OFF_RESULT_HIGH, 3, d);
    chk_val(d, 24'habcdec);
    $display("t_result done");
  endtask

  task automatic t_calib();
    logic [7:0] offs[9];
    offs = '{8'h22, 8'h24, 8'h26, 8'h28, 8'h2a, 8'h2c, 8'h2e, 8'h32, 8'h34};
    i_host.rd(OFF_PRESS_GAIN, 2, d);
    chk_val(d, 24'h0);
    i_host.wr(OFF_CALIB_CTL, 8'h25, ok);
    chk_bit(calib_read_en, 1'b1);
    i_host.rd(OFF_CALIB_CTL, 1, d);
    chk_val(d, 24'h25);
    foreach (offs[k]) begin
      i_host.rd(offs[k], 2, d);
      chk_val(d, {8'h0, offs[k], offs[k] + 8'h1});
    end
    i_host.wr(OFF_PRESS_GAIN, 8'h00, ok);
    i_host.rd(OFF_PRESS_GAIN, 2, d);
    chk_val(d, 24'h2223);
    i_host.wr(OFF_CALIB_CTL, 8'h65, ok);
    chk_bit(calib_read_en, 1'b0);
    $display("t_calib done");
  endtask

  task automatic t_addr();
    i_host.probe(7'h71, ok);
    chk_bit(ok, 1'b0);
    i_host.probe(7'h70, ok);
    chk_bit(ok, 1'b1);
    i_host.wr(8'h05, 8'hff, ok);
    i_host.rd(8'h05, 1, d);
    chk_val(d, 24'h0);
    i_host.rd(OFF_SENSE_REQ, 1, d);
    chk_val(d, 24'h20);
    i_host.rd(OFF_CONV_SETUP, 1, d);
    chk_val(d, 24'h02);
    $display("t_addr done");
  endtask

  // verdict and end of run
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // reset, then the scenarios in order
  initial begin
    rstn       = 1'b0;
    conv_valid = 1'b0;
    conv_data  = 24'h0;
    calib      = 144'h2223_2425_2627_2829_2a2b_2c2d_2e2f_3233_3435;
    repeat (4) @(posedge clock);
    #1;
    rstn = 1'b1;
    step(4);
    t_reset();
    t_mode();
    t_result();
    t_calib();
    t_addr();
    close_out();
  end
endmodule // tb
`default_nettype wire
